// file: fsp_defs.svh
// fsp_defs.svh: offsets, field positions, reset values of the flash
// security and protection register block.
// assumes: included by its bare name; definitions only.
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// register indices; byte address is four times the index
`define FSP_IDX_LOCK 6'h01
`define FSP_IDX_TEST 6'h02
`define FSP_IDX_CFG 6'h03
`define FSP_IDX_PROT 6'h04
`define FSP_IDX_STAT 6'h05
// nonvolatile bytes fetched by the reset sequence
`define FSP_NV_SEC_ADDR 16'hff0f
`define FSP_NV_PROT_ADDR 16'hff0d
// lock status fields
`define FSP_KEY_HI 7
`define FSP_KEY_LO 6
`define FSP_SEC_HI 1
`define FSP_SEC_LO 0
`define FSP_KEY_ON 2'h2
`define FSP_SEC_OPEN 2'h2
// flash config fields
`define FSP_CFG_BEIE 7
`define FSP_CFG_DONEIE 6
`define FSP_CFG_KEY_WRITE_ACCESS 5
`define FSP_CFG_RESET 8'h00
// protection fields
`define FSP_PROT_POL 7
`define FSP_PROT_NV 6
`define FSP_PROT_HIOFF 5
`define FSP_PROT_HIS_HI 4
`define FSP_PROT_HIS_LO 3
`define FSP_PROT_LOOFF 2
`define FSP_PROT_LOS_HI 1
`define FSP_PROT_LOS_LO 0
// status fields
`define FSP_STAT_BE 7
`define FSP_STAT_DONE 6
`define FSP_STAT_VIOL 5
// protected range geometry
`define FSP_HI_TOP 16'hffff
`define FSP_HI_UNIT 16'h0800
`define FSP_LO_BASE 16'h4000
`define FSP_LO_UNIT 16'h0200
// bus answers
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2
`endif

// file: fsp_pkg.sv
// fsp_pkg.sv: types shared by the flash security and protection block.
// assumes: compiled before any module that imports it.
package fsp_pkg;
  // kind of array operation offered for a protection check
  typedef enum logic [1:0] {
    FSP_OP_PROG,
    FSP_OP_ERASE,
    FSP_OP_MASS
  } fsp_op_t;
endpackage

// file: fsp_regs.sv
// fsp_regs.sv: security, configuration and protection registers of an
// embedded flash module, with an AXI4-Lite slave and a protection check.
// assumes: nonvolatile bytes valid while i_reset is high; command logic
// and flags on the same clock; one write and one read under way at most.
`timescale 1ns/10ps
`include "fsp_defs.svh"

module fsp_regs
  import fsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_nv_sec_byte,
  input wire logic [7:0] i_nv_prot_byte,
  input wire logic i_backdoor_ok,
  input wire logic i_cmd_buf_empty,
  input wire logic i_cmd_done,
  input wire logic i_op_valid,
  input wire fsp_op_t i_op_kind,
  input wire logic [15:0] i_op_addr,
  output logic o_op_go,
  output logic o_op_refused,
  output logic o_irq,
  output logic o_key_write_access,
  output logic o_backdoor_enabled,
  output logic o_secured
);

  // address inside a range of given base and length
  function automatic logic in_range(
    input logic [15:0] addr,
    input logic [15:0] base,
    input logic [15:0] len
  );
    logic [16:0] top;
    top = {1'b0, base} + {1'b0, len};
    in_range = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
  endfunction

  // range length: one unit doubled per size step
  function automatic logic [15:0] range_len(
    input logic [15:0] unit,
    input logic [1:0] size
  );
    range_len = unit << size;
  endfunction

  logic [7:0] lock_r;
  logic [7:0] cfg_r;
  logic [7:0] prot_r;
  logic viol_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [5:0] wr_idx_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic go_r;
  logic refused_r;
  logic irq_r;
  logic key_acc_r;
  logic key_on_r;
  logic secured_r;

  logic key_on;
  logic do_write;
  logic wr_lane;
  logic [5:0] rd_idx;
  logic [15:0] hi_len;
  logic [15:0] hi_base;
  logic in_lo;
  logic in_hi;
  logic area_prot;
  logic mass_ok;
  logic op_refuse;

  // write performed once both halves are held and no answer is pending
  assign do_write = !awready_r && !wready_r && !bvalid_r;
  assign wr_lane = do_write && wstrb0_r;
  assign rd_idx = i_s_axi_araddr[7:2];
  assign key_on = (lock_r[`FSP_KEY_HI:`FSP_KEY_LO] == `FSP_KEY_ON);

  // write address and data channels, taken in either order
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      wr_idx_r <= 6'h00;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        wr_idx_r <= i_s_axi_awaddr[7:2];
      end
      if (i_s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r <= i_s_axi_wdata;
        wstrb0_r <= i_s_axi_wstrb[0];
      end
      // reopen only after the answer is taken
      if (bvalid_r && i_s_axi_bready) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // write response; unmapped index answers slverr
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= `FSP_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      case (wr_idx_r)
        `FSP_IDX_LOCK, `FSP_IDX_TEST, `FSP_IDX_CFG,
        `FSP_IDX_PROT, `FSP_IDX_STAT: bresp_r <= `FSP_RESP_OKAY;
        default: bresp_r <= `FSP_RESP_SLVERR;
      endcase
    end else if (bvalid_r && i_s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // lock status: loaded in reset, never written by software
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lock_r <= i_nv_sec_byte;
    end else if (i_backdoor_ok) begin
      lock_r[`FSP_SEC_HI:`FSP_SEC_LO] <= `FSP_SEC_OPEN;
    end
    // no bus write reaches this register
  end

  // config: only enables and key access are stored, rest reads zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_r <= `FSP_CFG_RESET;
    end else if (wr_lane && wr_idx_r == `FSP_IDX_CFG) begin
      cfg_r[`FSP_CFG_BEIE] <= wdata_r[`FSP_CFG_BEIE];
      cfg_r[`FSP_CFG_DONEIE] <= wdata_r[`FSP_CFG_DONEIE];
      if (key_on) begin
        cfg_r[`FSP_CFG_KEY_WRITE_ACCESS] <= wdata_r[`FSP_CFG_KEY_WRITE_ACCESS];
      end
    end
  end

  // protection: polarity and range-off bits only fall, sizes gated
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prot_r <= i_nv_prot_byte;
    end else if (wr_lane && wr_idx_r == `FSP_IDX_PROT) begin
      prot_r[`FSP_PROT_POL] <= prot_r[`FSP_PROT_POL] & wdata_r[`FSP_PROT_POL];
      prot_r[`FSP_PROT_HIOFF] <= prot_r[`FSP_PROT_HIOFF] & wdata_r[`FSP_PROT_HIOFF];
      prot_r[`FSP_PROT_LOOFF] <= prot_r[`FSP_PROT_LOOFF] & wdata_r[`FSP_PROT_LOOFF];
      if (prot_r[`FSP_PROT_HIOFF]) begin
        prot_r[`FSP_PROT_HIS_HI:`FSP_PROT_HIS_LO] <=
          wdata_r[`FSP_PROT_HIS_HI:`FSP_PROT_HIS_LO];
      end
      if (prot_r[`FSP_PROT_LOOFF]) begin
        prot_r[`FSP_PROT_LOS_HI:`FSP_PROT_LOS_LO] <=
          wdata_r[`FSP_PROT_LOS_HI:`FSP_PROT_LOS_LO];
      end
    end
  end

  // protected area decode; upper range ends at the top of the map
  assign hi_len = range_len(`FSP_HI_UNIT, prot_r[`FSP_PROT_HIS_HI:`FSP_PROT_HIS_LO]);
  assign hi_base = `FSP_HI_TOP - hi_len + 16'h0001;
  assign in_hi = !prot_r[`FSP_PROT_HIOFF] && in_range(i_op_addr, hi_base, hi_len);
  assign in_lo = !prot_r[`FSP_PROT_LOOFF] && in_range(i_op_addr, `FSP_LO_BASE,
    range_len(`FSP_LO_UNIT, prot_r[`FSP_PROT_LOS_HI:`FSP_PROT_LOS_LO]));
  // polarity clear turns the enabled ranges into the only open holes
  assign area_prot = prot_r[`FSP_PROT_POL] ? (in_lo || in_hi) : !(in_lo || in_hi);
  assign mass_ok = prot_r[`FSP_PROT_POL] && prot_r[`FSP_PROT_HIOFF] &&
    prot_r[`FSP_PROT_LOOFF];
  assign op_refuse = (i_op_kind == FSP_OP_MASS) ? !mass_ok : area_prot;

  // verdict on each offered operation, one cycle later
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      go_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      go_r <= i_op_valid && !op_refuse;
      refused_r <= i_op_valid && op_refuse;
    end
  end

  // sticky violation flag; a new refusal wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      viol_r <= 1'b0;
    end else if (i_op_valid && op_refuse) begin
      viol_r <= 1'b1;
    end else if (wr_lane && wr_idx_r == `FSP_IDX_STAT && wdata_r[`FSP_STAT_VIOL]) begin
      viol_r <= 1'b0;
    end
  end

  // read channel: data captured at the address handshake
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `FSP_RESP_OKAY;
    end else if (i_s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `FSP_RESP_OKAY;
      case (rd_idx)
        `FSP_IDX_LOCK: rdata_r[7:0] <= lock_r;
        `FSP_IDX_TEST: rdata_r[7:0] <= 8'h00;
        `FSP_IDX_CFG: rdata_r[7:0] <= cfg_r;
        `FSP_IDX_PROT: rdata_r[7:0] <= prot_r;
        `FSP_IDX_STAT: begin
          rdata_r[`FSP_STAT_BE] <= i_cmd_buf_empty;
          rdata_r[`FSP_STAT_DONE] <= i_cmd_done;
          rdata_r[`FSP_STAT_VIOL] <= viol_r;
        end
        default: rresp_r <= `FSP_RESP_SLVERR;
      endcase
    end else if (rvalid_r && i_s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // interrupt request: level, follows enables and flags
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (cfg_r[`FSP_CFG_BEIE] && i_cmd_buf_empty) ||
        (cfg_r[`FSP_CFG_DONEIE] && i_cmd_done);
    end
  end

  // security view for the rest of the module, registered for timing
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      key_acc_r <= 1'b0;
      key_on_r <= 1'b0;
      secured_r <= 1'b1;
    end else begin
      key_acc_r <= cfg_r[`FSP_CFG_KEY_WRITE_ACCESS];
      key_on_r <= key_on;
      secured_r <= (lock_r[`FSP_SEC_HI:`FSP_SEC_LO] != `FSP_SEC_OPEN);
    end
  end

  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready = wready_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_op_go = go_r;
  assign o_op_refused = refused_r;
  assign o_irq = irq_r;
  assign o_key_write_access = key_acc_r;
  assign o_backdoor_enabled = key_on_r;
  assign o_secured = secured_r;

  // checks on the block's own behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence rd_test_s;
    i_s_axi_arvalid && arready_r && rd_idx == `FSP_IDX_TEST;
  endsequence

  sequence mass_bad_s;
    i_op_valid && i_op_kind == FSP_OP_MASS && !mass_ok;
  endsequence

  sequence wr_cfg_locked_s;
    wr_lane && wr_idx_r == `FSP_IDX_CFG && !key_on;
  endsequence

  lock_no_write_a: assert property (
    do_write && wr_idx_r == `FSP_IDX_LOCK && !i_backdoor_ok |=> $stable(lock_r))
    else $error("lock status changed by a bus write");

  test_reads_zero_a: assert property (
    rd_test_s |=> o_s_axi_rvalid && o_s_axi_rdata == 32'h0000_0000)
    else $error("test register read not zero");

  key_gate_a: assert property (
    wr_cfg_locked_s |=> $stable(cfg_r[`FSP_CFG_KEY_WRITE_ACCESS]))
    else $error("key access written while backdoor disabled");

  pol_one_way_a: assert property (
    !prot_r[`FSP_PROT_POL] |=> !prot_r[`FSP_PROT_POL])
    else $error("polarity rose from zero");

  lo_size_hold_a: assert property (
    !prot_r[`FSP_PROT_LOOFF] |=> $stable(prot_r[`FSP_PROT_LOS_HI:`FSP_PROT_LOS_LO]))
    else $error("lower size changed while range enabled");

  mass_refuse_a: assert property (
    mass_bad_s |=> o_op_refused && !o_op_go && viol_r)
    else $error("mass erase not refused");

  unsecure_a: assert property (
    i_backdoor_ok |=> lock_r[`FSP_SEC_HI:`FSP_SEC_LO] == `FSP_SEC_OPEN ##1 !o_secured)
    else $error("backdoor did not unsecure");

  irq_level_a: assert property (
    o_irq == $past((cfg_r[`FSP_CFG_BEIE] && i_cmd_buf_empty) ||
      (cfg_r[`FSP_CFG_DONEIE] && i_cmd_done)))
    else $error("irq does not follow enables and flags");

  irq_done_a: assert property (
    (cfg_r[`FSP_CFG_DONEIE] && i_cmd_done) [*2] |=> o_irq [*1])
    else $error("command done irq missing");

  write_answer_a: assert property (
    do_write |=> o_s_axi_bvalid throughout (!o_s_axi_awready [*1]))
    else $error("write not answered next cycle");

endmodule

// file: fsp_regs_tb.sv
// fsp_regs_tb.sv: self-checking bench for the flash security and protection registers.
// assumes: fsp_pkg and fsp_defs.svh compiled first; design assertions live in fsp_regs.
`timescale 1ns/10ps
`include "fsp_defs.svh"

module fsp_regs_tb
  import fsp_pkg::*;
;
  // one register row: address, data written, value read back, answer
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} fsp_row_t;

  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, nv_sec = 8'hb5, nv_prot = 8'hff;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic backdoor_ok = 1'b0, buf_empty = 1'b0, cmd_done = 1'b0, op_valid = 1'b0;
  fsp_op_t op_kind = FSP_OP_PROG;
  logic [15:0] op_addr = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, op_go, op_refused, irq, key_acc, bd_en, secured;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int bad_count = 0, comparisons = 0, cycles = 0;
  fsp_row_t rows [7] = '{
    '{8'h04, 8'h00, 8'hb5, `FSP_RESP_OKAY},
    '{8'h08, 8'hff, 8'h00, `FSP_RESP_OKAY},
    '{8'h0c, 8'hff, 8'he0, `FSP_RESP_OKAY},
    '{8'h10, 8'h3f, 8'h7f, `FSP_RESP_OKAY},
    '{8'h10, 8'h1a, 8'h5a, `FSP_RESP_OKAY},
    '{8'h10, 8'hff, 8'h5a, `FSP_RESP_OKAY},
    '{8'h40, 8'h55, 8'h00, `FSP_RESP_SLVERR}};

  fsp_regs u_fsp_regs (
    .i_clk(i_clk), .i_reset(i_reset),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_nv_sec_byte(nv_sec), .i_nv_prot_byte(nv_prot), .i_backdoor_ok(backdoor_ok),
    .i_cmd_buf_empty(buf_empty), .i_cmd_done(cmd_done),
    .i_op_valid(op_valid), .i_op_kind(op_kind), .i_op_addr(op_addr),
    .o_op_go(op_go), .o_op_refused(op_refused), .o_irq(irq),
    .o_key_write_access(key_acc), .o_backdoor_enabled(bd_en), .o_secured(secured)
  );

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // address and data offered together; each released at its own take
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one-cycle offer; answer is registered one edge later
  task automatic op(input fsp_op_t k, input logic [15:0] a, input logic go);
    @(posedge i_clk);
    op_kind <= k;
    op_addr <= a;
    op_valid <= 1'b1;
    @(posedge i_clk);
    op_valid <= 1'b0;
    #1;
    chk("op_go", op_go, go);
    chk("op_refused", op_refused, !go);
  endtask

  // flags change after the config write so the irq cause is unambiguous
  task automatic irq_case(input logic [7:0] cfg, input logic be, input logic dn, input logic exp);
    axi_wr(8'h0c, {24'h0, cfg}, resp);
    @(posedge i_clk);
    buf_empty <= be;
    cmd_done <= dn;
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq", irq, exp);
    chk("key_access", key_acc, cfg[5]);
    $display("test irq cfg %h done", cfg);
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("backdoor_enabled", bd_en, 1'b1);
    chk("secured", secured, 1'b1);
    axi_rd(8'h0c, rd, resp);
    chk("config_reset", rd, 32'h0);
    axi_rd(8'h10, rd, resp);
    chk("prot_loaded", rd, 32'hff);
    // all ranges off under polarity one: nothing protected, mass erase allowed
    op(FSP_OP_PROG, 16'hc000, 1'b1);
    op(FSP_OP_MASS, 16'h0000, 1'b1);
    // upper sector open, so the protection byte itself may be programmed
    op(FSP_OP_PROG, `FSP_NV_PROT_ADDR, 1'b1);
    $display("test reset values done");
    // ordinary register accesses from the table
    foreach (rows[i]) begin
      axi_wr(rows[i].a, {24'h0, rows[i].d}, resp);
      chk("bresp", resp, rows[i].r);
      axi_rd(rows[i].a, rd, resp);
      chk("rdata", rd, {24'h0, rows[i].e});
      chk("rresp", resp, rows[i].r);
      $display("test row %0d done", i);
    end
    // polarity zero: only the two enabled ranges stay unprotected
    op(FSP_OP_PROG, 16'hc000, 1'b1);
    op(FSP_OP_ERASE, 16'h47ff, 1'b1);
    op(FSP_OP_PROG, 16'h4800, 1'b0);
    op(FSP_OP_ERASE, 16'hbfff, 1'b0);
    op(FSP_OP_MASS, 16'h0000, 1'b0);
    axi_rd(8'h14, rd, resp);
    chk("violation_set", rd, 32'h20);
    axi_wr(8'h14, 32'h20, resp);
    axi_rd(8'h14, rd, resp);
    chk("violation_clear", rd, 32'h00);
    $display("test protection done");
    irq_case(8'h80, 1'b1, 1'b0, 1'b1);
    irq_case(8'h00, 1'b1, 1'b0, 1'b0);
    irq_case(8'h40, 1'b0, 1'b1, 1'b1);
    irq_case(8'h40, 1'b1, 1'b0, 1'b0);
    irq_case(8'he0, 1'b1, 1'b1, 1'b1);
    axi_rd(8'h14, rd, resp);
    chk("status_live", rd, 32'hc0);
    irq_case(8'h00, 1'b0, 1'b0, 1'b0);
    // backdoor success forces the lock state open, flags untouched
    @(posedge i_clk);
    backdoor_ok <= 1'b1;
    @(posedge i_clk);
    backdoor_ok <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("secured_after_key", secured, 1'b0);
    axi_rd(8'h04, rd, resp);
    chk("lock_after_key", rd, 32'hb6);
    $display("test backdoor done");
    // second reset: key disabled, unsecured, both ranges enabled under polarity one
    nv_sec <= 8'h42;
    nv_prot <= 8'h9b;
    do_reset();
    chk("backdoor_enabled", bd_en, 1'b0);
    chk("secured", secured, 1'b0);
    axi_wr(8'h0c, 32'he0, resp);
    axi_rd(8'h0c, rd, resp);
    chk("key_bit_locked", rd, 32'hc0);
    // low lane strobe off: answered, but nothing stored
    wstrb <= 4'h0;
    axi_wr(8'h0c, 32'h00, resp);
    wstrb <= 4'hf;
    chk("strobe_off_bresp", resp, `FSP_RESP_OKAY);
    axi_rd(8'h0c, rd, resp);
    chk("strobe_off_keep", rd, 32'hc0);
    op(FSP_OP_PROG, 16'hc000, 1'b0);
    op(FSP_OP_ERASE, 16'h4fff, 1'b0);
    op(FSP_OP_PROG, 16'h5000, 1'b1);
    op(FSP_OP_MASS, 16'h0000, 1'b0);
    // upper sector still protected: the protection byte cannot be reprogrammed
    op(FSP_OP_PROG, `FSP_NV_PROT_ADDR, 1'b0);
    axi_rd(8'h14, rd, resp);
    chk("violation_after_reset", rd, 32'h20);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
